// [digital_input_routing_matrix.sv]
// Implementation choices: the register offsets and the AXI4-Lite register port.
`include "di_routing_regs.svh"
module digital_input_routing_matrix
    import di_routing_pkg::*;
#(
    parameter int N_INPUTS = 5
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic [N_INPUTS-1:0] I_LOGIC_INPUT,
    input wire logic [11:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [11:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output func_s O_FUNC
);
    // ************************************************************
    // register storage
    // ************************************************************
    route_t route_q [N_INPUTS];
    logic [11:0] awaddr_q;
    logic aw_full_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_full_q;
    logic bvalid_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic rerr_q;
    logic berr_q;
    logic [N_INPUTS-1:0] in_q;
    logic do_write;
    logic [2:0] widx;
    logic wsel_route;

    assign S_AXI_AWREADY = !aw_full_q && !bvalid_q;
    assign S_AXI_WREADY = !w_full_q && !bvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = berr_q ? 2'b10 : 2'b00;
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rerr_q ? 2'b10 : 2'b00;

    // ************************************************************
    // write channel
    // ************************************************************
    // address and data are taken in either order; the write lands once both are held
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            aw_full_q <= 1'b0;
            awaddr_q <= 12'h000;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_full_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
        end else if (do_write) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            w_full_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_full_q <= 1'b1;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
        end else if (do_write) begin
            w_full_q <= 1'b0;
        end
    end

    assign do_write = aw_full_q && w_full_q;
    assign widx = awaddr_q[4:2];
    assign wsel_route = (awaddr_q[11:5] == 7'h00) && (widx < 3'(N_INPUTS))
        && (awaddr_q[1:0] == 2'b00);

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            bvalid_q <= 1'b0;
            berr_q <= 1'b0;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            berr_q <= !wsel_route;
        end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // ************************************************************
    // routing words, one per input
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < N_INPUTS; g++) begin : gen_route
            // routing word g serves input g
            always_ff @(posedge I_CLK) begin
                if (I_RST) begin
                    route_q[g] <= `ROUTE_RESET;
                end else if (do_write && wsel_route && (widx == 3'(g))) begin
                    if (wstrb_q[0]) route_q[g][7:0] <= wdata_q[7:0];
                    if (wstrb_q[1]) route_q[g][15:8] <= wdata_q[15:8];
                    if (wstrb_q[2]) route_q[g][19:16] <= wdata_q[19:16];
                end
            end
        end
    endgenerate

    // ************************************************************
    // checksums
    // ************************************************************
    // switch n weighs 2^(n-1), so the sum of set weights is the word itself
    function automatic logic [31:0] checksum(input route_t sw);
        logic [31:0] acc;
        acc = 32'h0000_0000;
        for (int b = 0; b < 20; b++) begin
            if (sw[b]) acc = acc + (32'h0000_0001 << b);
        end
        return acc;
    endfunction

    // ************************************************************
    // read channel
    // ************************************************************
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rerr_q <= 1'b0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_q <= 1'b1;
            rerr_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            if (S_AXI_ARADDR[1:0] != 2'b00) begin
                rerr_q <= 1'b1;
            end else if (S_AXI_ARADDR[11:5] == 7'h00 && S_AXI_ARADDR[4:2] < 3'(N_INPUTS)) begin
                rdata_q <= {12'h000, route_q[S_AXI_ARADDR[4:2]]};
            end else if (S_AXI_ARADDR[11:5] == 7'h01 && S_AXI_ARADDR[4:2] < 3'(N_INPUTS)) begin
                rdata_q <= checksum(route_q[S_AXI_ARADDR[4:2]]);
            end else if (S_AXI_ARADDR == `ACTIVE_GROUP_OFS) begin
                rdata_q <= {31'h0000_0000, O_FUNC.group_two_active};
            end else begin
                rerr_q <= 1'b1;
            end
        end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // ************************************************************
    // routing matrix
    // ************************************************************
    // one register stage on the inputs, and a second on the function outputs (func_q), keep the function outputs glitch free
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            in_q <= '0;
        end else begin
            in_q <= I_LOGIC_INPUT;
        end
    end

    function automatic logic any_on(input int sw);
        logic r;
        r = 1'b0;
        for (int k = 0; k < N_INPUTS; k++) begin
            r = r | (route_q[k][sw] & in_q[k]);
        end
        return r;
    endfunction

    func_s func_d;
    always_comb begin
        func_d = '0;
        // clears nest: switch 1 indications, 2 adds unlatch, 3 adds memory
        func_d.clear_indications = any_on(`SW_CLR_IND) | any_on(`SW_CLR_IND_UNLATCH)
            | any_on(`SW_CLR_ALL);
        func_d.unlatch_outputs = any_on(`SW_CLR_IND_UNLATCH) | any_on(`SW_CLR_ALL);
        func_d.clear_memorized = any_on(`SW_CLR_ALL);
        // with switch 4 clear the input has no say; default group one
        func_d.group_two_active = any_on(`SW_GROUP_SEL);
        func_d.time_sync = any_on(`SW_TIME_SYNC);
        func_d.external_trip = any_on(`SW_EXT_TRIP);
        func_d.breaker_failure_start = any_on(`SW_BF_START);
        func_d.lockout_trigger = any_on(`SW_LOCKOUT_SET);
        func_d.external_arc = any_on(`SW_EXT_ARC);
        func_d.lockout_reset = any_on(`SW_LOCKOUT_RESET);
        for (int s = 0; s < 5; s++) begin
            func_d.stage_block[s] = any_on(`SW_BLOCK_BASE + s);
        end
        func_d.auto_reclose_inhibit = any_on(`SW_AR_INHIBIT);
        func_d.reclose_inhibit = any_on(`SW_RECLOSE_INHIBIT);
        func_d.breaker_open = any_on(`SW_BRK_OPEN);
        func_d.breaker_closed = any_on(`SW_BRK_CLOSED);
        func_d.auto_reclose_initiate = any_on(`SW_AR_INITIATE);
    end

    func_s func_q;
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            func_q <= '0;
        end else begin
            func_q <= func_d;
        end
    end
    assign O_FUNC = func_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    chk_trip_route: assert property (
        (route_q[0][`SW_EXT_TRIP] && I_LOGIC_INPUT[0]) ##1 route_q[0][`SW_EXT_TRIP]
        |=> O_FUNC.external_trip)
        else $error("external trip not raised by input one");
    chk_trip_quiet: assert property (
        (((route_q[0][5] & I_LOGIC_INPUT[0]) | (route_q[1][5] & I_LOGIC_INPUT[1])
        | (route_q[2][5] & I_LOGIC_INPUT[2]) | (route_q[3][5] & I_LOGIC_INPUT[3])
        | (route_q[4][5] & I_LOGIC_INPUT[4])) == 1'b0) ##1 $stable(route_q[0])
        && $stable(route_q[1]) && $stable(route_q[2]) && $stable(route_q[3])
        && $stable(route_q[4]) |=> !O_FUNC.external_trip)
        else $error("external trip raised without routed input");
    chk_clear_nest: assert property (
        O_FUNC.unlatch_outputs |-> O_FUNC.clear_indications)
        else $error("unlatch without clearing indications");
    chk_mem_nest: assert property (
        O_FUNC.clear_memorized |-> O_FUNC.unlatch_outputs && O_FUNC.clear_indications)
        else $error("memory clear without unlatch");
    chk_group_sel: assert property (
        (route_q[2][`SW_GROUP_SEL] && I_LOGIC_INPUT[2]) ##1 route_q[2][`SW_GROUP_SEL]
        |=> O_FUNC.group_two_active)
        else $error("group two not selected");
    chk_group_idle: assert property (
        (route_q[0][3] | route_q[1][3] | route_q[2][3] | route_q[3][3] | route_q[4][3]) == 1'b0
        ##1 $stable(route_q[0]) && $stable(route_q[1]) && $stable(route_q[2])
        && $stable(route_q[3]) && $stable(route_q[4]) |=> !O_FUNC.group_two_active)
        else $error("group changed with switch four clear");
    chk_block_map: assert property (
        (route_q[4][`SW_BLOCK_BASE + 4] && I_LOGIC_INPUT[4])
        ##1 route_q[4][`SW_BLOCK_BASE + 4] |=> O_FUNC.stage_block[4])
        else $error("phase discontinuity block missing");
    chk_ar_init: assert property (
        (route_q[1][`SW_AR_INITIATE] && I_LOGIC_INPUT[1]) ##1 route_q[1][`SW_AR_INITIATE]
        |=> O_FUNC.auto_reclose_initiate)
        else $error("auto reclose initiation missing");
    chk_bresp_hold: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    chk_rdata_hold: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data changed while stalled");

    // every switch but 12..14 gets a route check from one input (switch 4 from two), so all five groups are exercised
    chk_clear_route: assert property (
        (route_q[0][`SW_CLR_IND] && I_LOGIC_INPUT[0])
        ##1 route_q[0][`SW_CLR_IND]
        |=> O_FUNC.clear_indications)
        else $error("indication clear not raised by input one");
    chk_unlatch_route: assert property (
        (route_q[1][`SW_CLR_IND_UNLATCH] && I_LOGIC_INPUT[1])
        ##1 route_q[1][`SW_CLR_IND_UNLATCH]
        |=> O_FUNC.unlatch_outputs && O_FUNC.clear_indications)
        else $error("unlatch not raised by input two");
    chk_memory_route: assert property (
        (route_q[2][`SW_CLR_ALL] && I_LOGIC_INPUT[2])
        ##1 route_q[2][`SW_CLR_ALL]
        |=> O_FUNC.clear_memorized)
        else $error("memory clear not raised by input three");
    chk_group_five: assert property (
        (route_q[4][`SW_GROUP_SEL] && I_LOGIC_INPUT[4])
        ##1 route_q[4][`SW_GROUP_SEL]
        |=> O_FUNC.group_two_active)
        else $error("group two not selected by input five");
    chk_sync_route: assert property (
        (route_q[3][`SW_TIME_SYNC] && I_LOGIC_INPUT[3])
        ##1 route_q[3][`SW_TIME_SYNC]
        |=> O_FUNC.time_sync)
        else $error("time sync not passed from input four");
    chk_bf_route: assert property (
        (route_q[2][`SW_BF_START] && I_LOGIC_INPUT[2])
        ##1 route_q[2][`SW_BF_START]
        |=> O_FUNC.breaker_failure_start)
        else $error("breaker failure start missing");
    chk_lock_route: assert property (
        (route_q[2][`SW_LOCKOUT_SET] && I_LOGIC_INPUT[2])
        ##1 route_q[2][`SW_LOCKOUT_SET]
        |=> O_FUNC.lockout_trigger)
        else $error("lockout trigger missing");
    chk_arc_route: assert property (
        (route_q[3][`SW_EXT_ARC] && I_LOGIC_INPUT[3])
        ##1 route_q[3][`SW_EXT_ARC]
        |=> O_FUNC.external_arc)
        else $error("external arc indication missing");
    chk_unlock_route: assert property (
        (route_q[3][`SW_LOCKOUT_RESET] && I_LOGIC_INPUT[3])
        ##1 route_q[3][`SW_LOCKOUT_RESET]
        |=> O_FUNC.lockout_reset)
        else $error("lockout reset missing");
    chk_block_low: assert property (
        (route_q[4][`SW_BLOCK_BASE] && I_LOGIC_INPUT[4])
        ##1 route_q[4][`SW_BLOCK_BASE]
        |=> O_FUNC.stage_block[0])
        else $error("low overcurrent block missing");
    chk_ar_inhibit: assert property (
        (route_q[0][`SW_AR_INHIBIT] && I_LOGIC_INPUT[0])
        ##1 route_q[0][`SW_AR_INHIBIT]
        |=> O_FUNC.auto_reclose_inhibit)
        else $error("auto reclose inhibit missing");
    chk_reclose_inh: assert property (
        (route_q[0][`SW_RECLOSE_INHIBIT] && I_LOGIC_INPUT[0])
        ##1 route_q[0][`SW_RECLOSE_INHIBIT]
        |=> O_FUNC.reclose_inhibit)
        else $error("reclose inhibit missing");
    chk_brk_open: assert property (
        (route_q[0][`SW_BRK_OPEN] && I_LOGIC_INPUT[0])
        ##1 route_q[0][`SW_BRK_OPEN]
        |=> O_FUNC.breaker_open)
        else $error("breaker open indication missing");
    chk_brk_closed: assert property (
        (route_q[0][`SW_BRK_CLOSED] && I_LOGIC_INPUT[0])
        ##1 route_q[0][`SW_BRK_CLOSED]
        |=> O_FUNC.breaker_closed)
        else $error("breaker closed indication missing");
    chk_csum_one: assert property (
        (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `CSUM_BASE_OFS)
        |=> S_AXI_RVALID && S_AXI_RDATA == {12'h000, $past(route_q[0])})
        else $error("checksum of group one wrong");
    chk_csum_five: assert property (
        (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == (`CSUM_BASE_OFS + 12'h010))
        |=> S_AXI_RVALID && S_AXI_RDATA == {12'h000, $past(route_q[4])})
        else $error("checksum of group five wrong");

    cov_write: cover property (S_AXI_BVALID && S_AXI_BREADY && !berr_q);
    cov_lock_clear: cover property (O_FUNC.lockout_reset && O_FUNC.external_arc);
    cov_group_two: cover property (O_FUNC.group_two_active);
    cov_read_csum: cover property (S_AXI_ARVALID && S_AXI_ARREADY
        && S_AXI_ARADDR[11:5] == 7'h01);
    cov_multi_in: cover property (O_FUNC.external_trip && O_FUNC.lockout_trigger);
endmodule

// [di_routing_regs.svh]
`ifndef DI_ROUTING_REGS_SVH
`define DI_ROUTING_REGS_SVH
// byte offsets of the five routing words, then five checksum words
`define ROUTE_BASE_OFS 12'h000
`define CSUM_BASE_OFS 12'h020
`define ACTIVE_GROUP_OFS 12'h040
`define ROUTE_RESET 20'h0_0000
// switch positions, zero based (switch n is bit n-1)
`define SW_CLR_IND 0
`define SW_CLR_IND_UNLATCH 1
`define SW_CLR_ALL 2
`define SW_GROUP_SEL 3
`define SW_TIME_SYNC 4
`define SW_EXT_TRIP 5
`define SW_BF_START 6
`define SW_LOCKOUT_SET 7
`define SW_EXT_ARC 8
`define SW_LOCKOUT_RESET 9
`define SW_BLOCK_BASE 10
`define SW_AR_INHIBIT 15
`define SW_RECLOSE_INHIBIT 16
`define SW_BRK_OPEN 17
`define SW_BRK_CLOSED 18
`define SW_AR_INITIATE 19
`endif

// [di_routing_pkg.sv]
package di_routing_pkg;
    typedef logic [19:0] route_t;
    typedef struct packed {
        logic clear_indications;
        logic unlatch_outputs;
        logic clear_memorized;
        logic group_two_active;
        logic time_sync;
        logic external_trip;
        logic breaker_failure_start;
        logic lockout_trigger;
        logic external_arc;
        logic lockout_reset;
        logic [4:0] stage_block;
        logic auto_reclose_inhibit;
        logic reclose_inhibit;
        logic breaker_open;
        logic breaker_closed;
        logic auto_reclose_initiate;
    } func_s;
endpackage

// [relay_function_model.sv]
module relay_function_model
    import di_routing_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire func_s func,
    output logic lockout_q,
    output logic group_two_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // trip lockout and setting group on the function side
    // ****************************************
    // reset wins over trigger so a stuck trigger input cannot hold lockout forever
    always_ff @(posedge clk) begin
        if (rst) begin
            lockout_q <= 1'b0;
        end else if (func.lockout_reset) begin
            lockout_q <= 1'b0;
        end else if (func.lockout_trigger) begin
            lockout_q <= 1'b1;
        end
    end
    // switch 4 is kept equal in both groups, so the group follows the level alone
    always_ff @(posedge clk) begin
        group_two_q <= rst ? 1'b0 : func.group_two_active;
    end
endmodule

// [digital_input_routing_matrix_tb_top.sv]
module digital_input_routing_matrix_tb_top;
    import di_routing_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals
    // ****************************************
    typedef struct {int k; route_t w; logic [4:0] din;} row_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] din = 5'h00;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [3:0] wstrb = 4'hF;
    logic lock, grp;
    logic [31:0] rd;
    logic [19:0] e;
    func_s func;
    route_t rt [5];
    row_s rows [8];
    int num_errors = 0;
    int n_tests = 0;
    always #12.5 clk = ~clk;
    digital_input_routing_matrix #(.N_INPUTS(5)) uut (.I_CLK(clk), .I_RST(rst),
        .I_LOGIC_INPUT(din), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .O_FUNC(func));
    relay_function_model partner (.clk(clk), .rst(rst), .func(func), .lockout_q(lock),
        .group_two_q(grp));
    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // enter just after a rising edge; one spare edge at the end keeps strobes apart
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    // bench's own view of the matrix: OR over inputs of enabled switches
    function automatic logic [19:0] expect_func(input logic [4:0] act);
        logic [19:0] s;
        s = 20'h0_0000;
        for (int k = 0; k < 5; k++) s |= act[k] ? rt[k] : 20'h0_0000;
        return {s[0] | s[1] | s[2], s[1] | s[2], s[2], s[3], s[4], s[5], s[6], s[7], s[8],
            s[9], s[14:10], s[15], s[16], s[17], s[18], s[19]};
    endfunction
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rows = '{'{0, 20'h0_0007, 5'h01}, '{1, 20'h0_0018, 5'h02}, '{1, 20'h0_0018, 5'h1D},
            '{2, 20'h0_00E0, 5'h04}, '{3, 20'h0_0300, 5'h08}, '{4, 20'h0_7C00, 5'h10},
            '{0, 20'hF_8000, 5'h1F}, '{3, 20'h0_0320, 5'h18}};
        foreach (rt[k]) rt[k] = 20'h0_0000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 5; k++) begin
            axi_rd(12'(4 * k), rd, rsp);
            check("route after reset", 32'h0000_0000, rd);
        end
        foreach (rows[i]) begin
            rt[rows[i].k] = rows[i].w;
            axi_wr(12'(4 * rows[i].k), 32'(rows[i].w), rsp);
            check("write resp", 32'h0000_0000, 32'(rsp));
            din <= rows[i].din;
            repeat (3) @(posedge clk);
            e = expect_func(rows[i].din);
            check("functions", 32'(e), 32'(func));
            axi_rd(12'h020 + 12'(4 * rows[i].k), rd, rsp);
            check("checksum", 32'(rows[i].w), rd);
            axi_rd(12'h040, rd, rsp);
            check("active group", 32'(e[16]), rd);
            check("partner group", 32'(e[16]), 32'(grp));
            if (e[10]) check("partner lockout", 32'h0000_0000, 32'(lock));
            else if (e[12]) check("partner lockout", 32'h0000_0001, 32'(lock));
            $display("row %0d done", i);
        end
        axi_wr(12'h020, 32'h000F_FFFF, rsp);
        check("checksum write resp", 32'h0000_0002, 32'(rsp));
        axi_rd(12'h020, rd, rsp);
        check("checksum unchanged", 32'(rt[0]), rd);
        axi_rd(12'h044, rd, rsp);
        check("unmapped read resp", 32'h0000_0002, 32'(rsp));
        axi_wr(12'h006, 32'h0000_0001, rsp);
        check("unaligned write resp", 32'h0000_0002, 32'(rsp));
        axi_wr(12'h008, 32'hFFF0_0020, rsp);
        axi_rd(12'h008, rd, rsp);
        check("upper bits ignored", 32'h0000_0020, rd);
        // only the low byte lane is enabled, so switches 9..20 keep their value
        wstrb <= 4'h1;
        axi_wr(12'h00C, 32'h000F_FFFF, rsp);
        wstrb <= 4'hF;
        axi_rd(12'h00C, rd, rsp);
        check("byte strobe", {12'h000, rt[3] | 20'h0_00FF}, rd);
        $display("register access tests done");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("functions after reset", 32'h0000_0000, 32'(func));
        axi_rd(12'h000, rd, rsp);
        check("route after second reset", 32'h0000_0000, rd);
        $display("mid-run reset test done");
        summarize();
    end
endmodule
